// ===== src/panel_ctl_defs.svh
// constants for the panel meter control line and message logic
`ifndef PANEL_CTL_DEFS_SVH
`define PANEL_CTL_DEFS_SVH

`define ADR_CTRL          4'h0
`define ADR_STATUS        4'h1
`define ADR_LIVE          4'h2
`define ADR_SHOWN         4'h3
`define ADR_HIGH          4'h4
`define ADR_LOW           4'h5
`define ADR_ACTION        4'h6
`define ADR_FAULTS        4'h7

`define CTRL_RESET_SCOPE  0
`define CTRL_PRINT_EN     1
`define CTRL_ALARM_CLR_EN 2
`define CTRL_RESET_VAL    3'h0

`define ACT_CFG_REQ       0
`define ACT_SETUP_REQ     1
`define ACT_CHANGED       2

`define DISP_MAX          24'hF423F
`define DEBOUNCE_NS       5000000
`define CLK_NS            10
`define DEBOUNCE_CYC      ((`DEBOUNCE_NS + `CLK_NS - 1) / `CLK_NS)
`define FLASH_NS          250000000
`define FLASH_CYC         (`FLASH_NS / `CLK_NS)
`define MSG_NS            1000000000
`define MSG_CYC           (`MSG_NS / `CLK_NS)
`define BAUD_CYC          16'd10417

`endif

// ===== src/panel_ctl_pkg.sv
// types for the panel meter control line and message logic
package panel_ctl_pkg;
    typedef enum logic [15:0] {
        MSG_NONE    = 16'h0001,
        MSG_NINES   = 16'h0002,
        MSG_OFS_OVF = 16'h0004,
        MSG_SP_OVF  = 16'h0008,
        MSG_STORED  = 16'h0010,
        MSG_NOSTOR  = 16'h0020,
        MSG_OVLD    = 16'h0040,
        MSG_POPEN   = 16'h0080,
        MSG_NOPEN   = 16'h0100,
        MSG_IOVSC   = 16'h0200,
        MSG_ROVSC   = 16'h0400,
        MSG_CBOVF   = 16'h0800,
        MSG_UOMOVF  = 16'h1000,
        MSG_SERIAL  = 16'h2000,
        MSG_HRESET  = 16'h4000
    } msg_t;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SEND = 3'b010,
        TX_GAP  = 3'b100
    } tx_state_t;
endpackage : panel_ctl_pkg

// ===== src/panel_meter_ctl.sv
// panel meter control lines, status messages and register slave
// Functional notes
// (R1) peak line low shows flashing highest reading
// (R2) valley line low shows flashing lowest reading
// (R3) reset line: hard reset or peak/valley clear
// (R4) hold freezes display, other outputs keep updating; here the peak/valley view and the all-nines value still override hold
// (R5) lockout blocks config, storage, setup entry
// (R6) print line starts serial printout when enabled
// (R7) print line clears alarm latches when enabled
// (R8) aux serial uses RS-232 framing at CMOS
// (R9) four open-collector setpoint and alarm outputs
// (R10) active decimal overflow flashes all nines
// (R11) offset overflow flashes offset error
// (R12) setpoint overflow flashes briefly, back to run
// (R13) shown magnitude clamped to six nines
// (R14) changed parameter flashes stored/not-stored, then advances
// (R15) submenu confirmation only on menu advance
// (R16) over range flashes positive overload
// (R17) open sensor with jumper flashes positive open
// (R18) under range with jumper flashes negative open
// (R19) input scaling overflow flashes input overscale
// (R20) reading scaling overflow flashes reading overscale
// (R21) rounding step overflow flashes count-by overflow
// (R22) unit suffix overflow flashes unit overflow
// (R23) input overscale outranks reading overscale
// (R24) config while serial busy shows busy, refused
// (R25) control lines active low, synced, debounced
// (R26) single message by fixed priority
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`include "panel_ctl_defs.svh"

module panel_meter_ctl #(
    parameter int DEBOUNCE = `DEBOUNCE_CYC,
    parameter int FLASH    = `FLASH_CYC,
    parameter int MSG_TIME = `MSG_CYC,
    parameter int BAUD     = `BAUD_CYC
) (
    input  wire logic        clk_i,            // 100 MHz clock
    input  wire logic        rst_i,            // sync reset, active high
    input  wire logic [3:0]  wb_adr_i,         // word address
    input  wire logic [31:0] wb_dat_i,         // write data
    output logic      [31:0] wb_dat_o,         // read data
    input  wire logic        wb_we_i,          // write enable
    input  wire logic [3:0]  wb_sel_i,         // byte selects
    input  wire logic        wb_cyc_i,         // cycle
    input  wire logic        wb_stb_i,         // strobe
    output logic             wb_ack_o,         // acknowledge
    input  wire logic        peak_sel_n_i,     // peak select pin, low active
    input  wire logic        valley_sel_n_i,   // valley select pin, low active
    input  wire logic        ext_reset_n_i,    // reset pin, low active
    input  wire logic        hold_n_i,         // display hold pin, low active
    input  wire logic        lockout_n_i,      // lockout pin, low active
    input  wire logic        print_n_i,        // print/alarm reset pin, low active
    input  wire logic        aux_rx_i,         // aux serial receive pin
    output logic             aux_tx_o,         // aux serial transmit pin
    input  wire logic        sample_valid_i,   // new reading strobe
    input  wire logic [23:0] sample_i,         // live magnitude
    input  wire logic [3:0]  sp_trip_i,        // setpoint comparator states
    input  wire logic [3:0]  alarm_latching_i, // latch enable per output
    input  wire logic        serial_busy_i,    // serial port communicating
    input  wire logic        in_setup_i,       // meter in setup mode
    input  wire logic        in_submenu_i,     // inside a submenu
    input  wire logic        menu_advance_i,   // menu pressed to next item
    input  wire logic        store_ok_i,       // nonvolatile write succeeded
    output logic             setpoint_one_output_oe_o,  // low-side drive sp1
    output logic             setpoint_two_output_oe_o,  // low-side drive sp2
    output logic             first_alarm_output_oe_o,   // low-side drive al1
    output logic             second_alarm_output_oe_o,  // low-side drive al2
    output logic [23:0]      disp_value_o,     // value on display
    output logic             disp_blank_o,     // flash phase blanking
    output panel_ctl_pkg::msg_t disp_msg_o,    // message on display
    output logic             hard_reset_o,     // full meter reset pulse
    output logic             enter_setup_o,    // setup entry granted pulse
    output logic             cfg_apply_o,      // config change granted pulse
    output logic             print_start_o     // printout started pulse
);
    import panel_ctl_pkg::*;

    localparam int NPIN = 6;
    localparam int PK = 0, VL = 1, RS = 2, HD = 3, LK = 4, PR = 5;

    typedef struct packed {
        logic [NPIN-1:0] s1, s2, act;
        logic [NPIN-1:0][22:0] deb;
        logic [2:0]  ctrl;
        logic [8:0]  faults;
        logic [23:0] live, high, low, shown;
        logic [3:0]  latch, sp_out;
        logic [27:0] flash_cnt;
        logic        flash_ph;
        msg_t        tmsg;
        logic [29:0] tmsg_cnt;
        logic        blank;
        msg_t        msg;
        logic        ack;
        logic [31:0] rdat;
        logic        hres, setup, apply, prn;
        tx_state_t   tx;
        logic [9:0]  txsh;
        logic [3:0]  txbit;
        logic [15:0] txcnt;
        logic        txo;
        logic        rx1, rx2;
    } st_t;

    st_t st_r, st_nxt;

    function automatic logic [23:0] clamp(input logic [23:0] v);
        // display limited to six digits
        clamp = (v > `DISP_MAX) ? 24'(`DISP_MAX) : v;
    endfunction : clamp

    logic [NPIN-1:0] pins;
    assign pins = {print_n_i, lockout_n_i, hold_n_i, ext_reset_n_i, valley_sel_n_i, peak_sel_n_i};

    always_comb begin
        logic [NPIN-1:0] rise;
        logic [3:0]      word_sel;
        logic            wr, cfg_req, setup_req;
        st_nxt    = st_r;
        rise      = '0;
        cfg_req   = 1'b0;
        setup_req = 1'b0;
        wr        = wb_cyc_i && wb_stb_i && wb_we_i && !st_r.ack;
        word_sel  = wb_sel_i;
        st_nxt.hres  = 1'b0;
        st_nxt.setup = 1'b0;
        st_nxt.apply = 1'b0;
        st_nxt.prn   = 1'b0;
        st_nxt.rx1   = aux_rx_i;
        st_nxt.rx2   = st_r.rx1;
        // (R25) invert, sync, debounce
        for (int i = 0; i < NPIN; i++) begin
            st_nxt.s1[i] = ~pins[i];
            st_nxt.s2[i] = st_r.s1[i];
            if (st_r.s2[i] == st_r.act[i]) begin
                st_nxt.deb[i] = '0;
            end else if (st_r.deb[i] >= 23'(DEBOUNCE - 1)) begin
                st_nxt.deb[i] = '0;
                st_nxt.act[i] = st_r.s2[i];
                rise[i]       = st_r.s2[i];
            end else begin
                st_nxt.deb[i] = st_r.deb[i] + 23'd1;
            end
        end
        if (st_r.flash_cnt >= 28'(FLASH - 1)) begin
            st_nxt.flash_cnt = '0;
            st_nxt.flash_ph  = ~st_r.flash_ph;
        end else begin
            st_nxt.flash_cnt = st_r.flash_cnt + 28'd1;
        end
        // (R4) peak/valley tracking continues under hold
        if (sample_valid_i) begin
            st_nxt.live = clamp(sample_i);
            if (clamp(sample_i) > st_r.high) st_nxt.high = clamp(sample_i);
            if (clamp(sample_i) < st_r.low) st_nxt.low = clamp(sample_i);
        end
        // (R3) reset scope select
        if (rise[RS]) begin
            if (st_r.ctrl[`CTRL_RESET_SCOPE]) begin
                st_nxt.high = '0;
                st_nxt.low  = 24'(`DISP_MAX);
            end else begin
                st_nxt.hres = 1'b1;
            end
        end
        // (R9) latched setpoint and alarm drive
        for (int j = 0; j < 4; j++) begin
            if (sp_trip_i[j] && alarm_latching_i[j]) st_nxt.latch[j] = 1'b1;
        end
        // (R7) line alarm clear; a trip in the same cycle wins
        if (rise[PR] && st_r.ctrl[`CTRL_ALARM_CLR_EN]) begin
            st_nxt.latch = sp_trip_i & alarm_latching_i;
        end
        st_nxt.sp_out = sp_trip_i | st_nxt.latch;
        // (R6) print on line
        if (rise[PR] && st_r.ctrl[`CTRL_PRINT_EN] && st_r.tx == TX_IDLE) begin
            st_nxt.prn = 1'b1;
        end
        // register bus
        st_nxt.ack = wb_cyc_i && wb_stb_i && !st_r.ack;
        if (wr && word_sel[0]) begin
            unique case (wb_adr_i)
                `ADR_CTRL:   st_nxt.ctrl = wb_dat_i[2:0];
                `ADR_FAULTS: st_nxt.faults = wb_dat_i[8:0];
                `ADR_ACTION: begin
                    cfg_req   = wb_dat_i[`ACT_CFG_REQ];
                    setup_req = wb_dat_i[`ACT_SETUP_REQ];
                end
                default: ;
            endcase
        end
        unique case (wb_adr_i)
            `ADR_CTRL:   st_nxt.rdat = {29'h0, st_r.ctrl};
            `ADR_STATUS: st_nxt.rdat = {16'h0, st_r.msg != MSG_NONE,
                                        3'h0, st_r.latch, 2'h0, st_r.act};
            `ADR_LIVE:   st_nxt.rdat = {8'h0, st_r.live};
            `ADR_SHOWN:  st_nxt.rdat = {8'h0, st_r.shown};
            `ADR_HIGH:   st_nxt.rdat = {8'h0, st_r.high};
            `ADR_LOW:    st_nxt.rdat = {8'h0, st_r.low};
            `ADR_FAULTS: st_nxt.rdat = {23'h0, st_r.faults};
            default:     st_nxt.rdat = 32'h0;
        endcase
        // (R5) lockout and (R24) serial busy gate config
        if (cfg_req) begin
            if (serial_busy_i) begin
                st_nxt.tmsg     = MSG_SERIAL;
                st_nxt.tmsg_cnt = 30'(MSG_TIME);
            end else if (!st_r.act[LK]) begin
                st_nxt.apply = 1'b1;
            end
        end
        // (R5) no setup entry under lockout
        if (setup_req && !in_setup_i && !st_r.act[LK]) st_nxt.setup = 1'b1;
        // (R14) (R15) confirmation only on menu advance
        if (menu_advance_i && in_setup_i && wr && wb_adr_i == `ADR_ACTION && wb_dat_i[`ACT_CHANGED]) begin
            st_nxt.tmsg     = (store_ok_i && !st_r.act[LK]) ? MSG_STORED : MSG_NOSTOR;
            st_nxt.tmsg_cnt = 30'(MSG_TIME);
        end else if (menu_advance_i && !in_submenu_i && st_r.tmsg == MSG_NONE && in_setup_i) begin
            st_nxt.tmsg     = (store_ok_i && !st_r.act[LK]) ? MSG_STORED : MSG_NOSTOR;
            st_nxt.tmsg_cnt = 30'(MSG_TIME);
        end
        // (R12) setpoint overflow message times out to run
        if (st_r.faults[2] && st_r.tmsg == MSG_NONE) begin
            st_nxt.tmsg     = MSG_SP_OVF;
            st_nxt.tmsg_cnt = 30'(MSG_TIME);
            st_nxt.faults[2] = wr && word_sel[0] && wb_adr_i == `ADR_FAULTS && wb_dat_i[2];
        end
        if (st_r.tmsg != MSG_NONE) begin
            if (st_r.tmsg_cnt == 30'h0) st_nxt.tmsg = MSG_NONE;
            else st_nxt.tmsg_cnt = st_r.tmsg_cnt - 30'd1;
        end
        if (st_r.hres) begin
            st_nxt.tmsg     = MSG_HRESET;
            st_nxt.tmsg_cnt = 30'(MSG_TIME);
        end
        // (R26) (R16) (R17) (R18) (R19) (R23) (R20) (R21) (R11) (R22) (R10) priority
        if (st_r.tmsg != MSG_NONE)  st_nxt.msg = st_r.tmsg;
        else if (st_r.faults[7])    st_nxt.msg = MSG_OVLD;
        else if (st_r.faults[6])    st_nxt.msg = MSG_POPEN;
        else if (st_r.faults[5])    st_nxt.msg = MSG_NOPEN;
        else if (st_r.faults[4])    st_nxt.msg = MSG_IOVSC;
        else if (st_r.faults[3])    st_nxt.msg = MSG_ROVSC;
        else if (st_r.faults[1])    st_nxt.msg = MSG_CBOVF;
        else if (st_r.faults[8])    st_nxt.msg = MSG_OFS_OVF;
        else if (st_r.faults[0])    st_nxt.msg = MSG_UOMOVF;
        else if (sample_valid_i ? (sample_i > `DISP_MAX) : (st_r.msg == MSG_NINES)) st_nxt.msg = MSG_NINES;
        else                        st_nxt.msg = MSG_NONE;
        // (R1) (R2) peak/valley view; (R4) hold freezes; (R13) clamp
        if (st_r.act[PK])               st_nxt.shown = st_r.high;
        else if (st_r.act[VL])          st_nxt.shown = st_r.low;
        else if (st_r.msg == MSG_NINES) st_nxt.shown = 24'(`DISP_MAX);
        else if (!st_r.act[HD])         st_nxt.shown = st_r.live;
        st_nxt.blank = (st_r.act[PK] || st_r.act[VL] || st_r.msg != MSG_NONE) && st_r.flash_ph;
        // (R8) print frame: start, 8 data lsb first, stop
        unique case (st_r.tx)
            TX_IDLE: begin
                st_nxt.txo = 1'b1;
                if (st_r.prn) begin
                    st_nxt.tx    = TX_SEND;
                    st_nxt.txsh  = {1'b1, st_r.shown[7:0], 1'b0};
                    st_nxt.txbit = 4'h0;
                    st_nxt.txcnt = '0;
                end
            end
            TX_SEND: begin
                st_nxt.txo = st_r.txsh[0];
                if (st_r.txcnt >= 16'(BAUD - 1)) begin
                    st_nxt.txcnt = '0;
                    st_nxt.txsh  = {1'b1, st_r.txsh[9:1]};
                    st_nxt.txbit = st_r.txbit + 4'h1;
                    if (st_r.txbit == 4'h9) st_nxt.tx = TX_GAP;
                end else begin
                    st_nxt.txcnt = st_r.txcnt + 16'd1;
                end
            end
            TX_GAP: begin
                st_nxt.txo = 1'b1;
                st_nxt.tx  = TX_IDLE;
            end
            default: st_nxt.tx = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r        <= '0;
            st_r.ctrl   <= `CTRL_RESET_VAL;
            st_r.low    <= 24'(`DISP_MAX);
            st_r.tmsg   <= MSG_NONE;
            st_r.msg    <= MSG_NONE;
            st_r.tx     <= TX_IDLE;
            st_r.txo    <= 1'b1;
            st_r.txsh   <= 10'h3FF;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o                 = st_r.rdat;
    assign wb_ack_o                 = st_r.ack;
    assign aux_tx_o                 = st_r.txo;
    assign setpoint_one_output_oe_o = st_r.sp_out[0];
    assign setpoint_two_output_oe_o = st_r.sp_out[1];
    assign first_alarm_output_oe_o  = st_r.sp_out[2];
    assign second_alarm_output_oe_o = st_r.sp_out[3];
    assign disp_value_o             = st_r.shown;
    assign disp_blank_o             = st_r.blank;
    assign disp_msg_o               = st_r.msg;
    assign hard_reset_o             = st_r.hres;
    assign enter_setup_o            = st_r.setup;
    assign cfg_apply_o              = st_r.apply;
    assign print_start_o            = st_r.prn;
endmodule : panel_meter_ctl

// ===== test/switch_panel.sv
// external switches that ground the meter control lines
`timescale 1ns/100ps
module switch_panel (
    input  wire logic [5:0] press_i,  // switch closed per line
    output logic      [5:0] pin_n_o,  // lines, pulled up when open
    output logic            aux_rx_o  // receive line
);
    assign pin_n_o  = ~press_i;
    assign aux_rx_o = 1'b1;
endmodule : switch_panel

// ===== test/panel_ctl_monitor.sv
// assertions on the panel meter control ports
`timescale 1ns/100ps
module panel_ctl_monitor
    import panel_ctl_pkg::*;
(
    input wire logic        clk_i,                    // clock
    input wire logic        rst_i,                    // reset
    input wire logic        wb_cyc_i,                 // cycle
    input wire logic        wb_stb_i,                 // strobe
    input wire logic        wb_ack_o,                 // ack
    input wire logic        hold_n_i,                 // hold pin
    input wire logic        lockout_n_i,              // lockout pin
    input wire logic        peak_sel_n_i,             // peak pin
    input wire logic        valley_sel_n_i,           // valley pin
    input wire logic        ext_reset_n_i,            // reset pin
    input wire logic [3:0]  sp_trip_i,                // trips
    input wire logic        serial_busy_i,            // serial busy
    input wire logic        setpoint_one_output_oe_o, // sp1 drive
    input wire logic        setpoint_two_output_oe_o, // sp2 drive
    input wire logic        first_alarm_output_oe_o,  // al1 drive
    input wire logic        second_alarm_output_oe_o, // al2 drive
    input wire logic [23:0] disp_value_o,             // shown value
    input wire msg_t        disp_msg_o,               // message
    input wire logic        hard_reset_o,             // hard reset
    input wire logic        enter_setup_o,            // setup grant
    input wire logic        cfg_apply_o,              // config grant
    input wire logic        print_start_o             // print start
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_locked;
        !lockout_n_i [*8] ##1 !lockout_n_i ##1 !lockout_n_i;
    endsequence
    sequence s_frozen;
        (!hold_n_i && peak_sel_n_i && valley_sel_n_i && ext_reset_n_i) [*8];
    endsequence
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged");
    a_clamp_six: assert property (disp_value_o <= 24'hF423F)
        else $error("shown value above six nines");
    a_single_msg: assert property ($onehot(disp_msg_o))
        else $error("message not one-hot");
    a_trip_drive: assert property (|sp_trip_i |=> ({second_alarm_output_oe_o, first_alarm_output_oe_o,
        setpoint_two_output_oe_o, setpoint_one_output_oe_o} & $past(sp_trip_i)) == $past(sp_trip_i))
        else $error("tripped output not driven");
    a_reset_pulse: assert property (hard_reset_o |=> !hard_reset_o)
        else $error("hard reset not a pulse");
    a_print_pulse: assert property (print_start_o |=> !print_start_o)
        else $error("print start not a pulse");
    a_lock_refuse: assert property (s_locked |-> !enter_setup_o && !cfg_apply_o)
        else $error("grant while locked");
    a_busy_refuse: assert property (serial_busy_i [*2] |-> !cfg_apply_o)
        else $error("config applied while serial busy");
    a_hold_still: assert property (s_frozen |=> $stable(disp_value_o))
        else $error("display moved under hold");
endmodule : panel_ctl_monitor
bind panel_meter_ctl panel_ctl_monitor u_mon (.*);

// ===== test/testbench.sv
// self-checking bench for the panel meter control block
`timescale 1ns/100ps
module testbench;
    import panel_ctl_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic        wb_we_i = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        sample_valid_i = 1'b0;
    logic [23:0] sample_i = 24'h0;
    logic [3:0]  sp_trip_i = 4'h0;
    logic [3:0]  alarm_latching_i = 4'h0;
    logic        serial_busy_i = 1'b0;
    logic        in_setup_i = 1'b0, in_submenu_i = 1'b0, menu_advance_i = 1'b0, store_ok_i = 1'b0;
    logic [5:0]  press = 6'h00;
    logic [5:0]  pin_n;
    logic [3:0]  oe;
    logic [31:0] wb_dat_o, q;
    logic [23:0] disp_value_o;
    logic        wb_ack_o, aux_rx_i, aux_tx_o, disp_blank_o;
    logic        hard_reset_o, enter_setup_o, cfg_apply_o, print_start_o;
    msg_t        disp_msg_o;
    int          n_errors = 0;
    int          checked = 0;
    int          cycles = 0;
    int          cnt [5] = '{0, 0, 0, 0, 0};
    switch_panel u_sw (.press_i(press), .pin_n_o(pin_n), .aux_rx_o(aux_rx_i));
    panel_meter_ctl #(.DEBOUNCE(4), .FLASH(8), .MSG_TIME(16), .BAUD(4)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_we_i(wb_we_i), .wb_sel_i(4'hF), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .peak_sel_n_i(pin_n[0]), .valley_sel_n_i(pin_n[1]), .ext_reset_n_i(pin_n[2]), .hold_n_i(pin_n[3]),
        .lockout_n_i(pin_n[4]), .print_n_i(pin_n[5]), .aux_rx_i(aux_rx_i), .aux_tx_o(aux_tx_o),
        .sample_valid_i(sample_valid_i), .sample_i(sample_i), .sp_trip_i(sp_trip_i),
        .alarm_latching_i(alarm_latching_i), .serial_busy_i(serial_busy_i), .in_setup_i(in_setup_i),
        .in_submenu_i(in_submenu_i), .menu_advance_i(menu_advance_i), .store_ok_i(store_ok_i),
        .setpoint_one_output_oe_o(oe[0]), .setpoint_two_output_oe_o(oe[1]), .first_alarm_output_oe_o(oe[2]),
        .second_alarm_output_oe_o(oe[3]), .disp_value_o(disp_value_o), .disp_blank_o(disp_blank_o),
        .disp_msg_o(disp_msg_o), .hard_reset_o(hard_reset_o), .enter_setup_o(enter_setup_o),
        .cfg_apply_o(cfg_apply_o), .print_start_o(print_start_o));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cnt[0] += (hard_reset_o === 1'b1);
        cnt[1] += (enter_setup_o === 1'b1);
        cnt[2] += (cfg_apply_o === 1'b1);
        cnt[3] += (print_start_o === 1'b1);
        cnt[4] += (aux_tx_o === 1'b0);
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && k < 5000) begin
            @(posedge clk_i);
            k++;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic pin(input int i, input logic v);
        press[i] <= v;
        repeat (12) @(posedge clk_i);
    endtask : pin
    task automatic smp(input logic [23:0] v);
        sample_i       <= v;
        sample_valid_i <= 1'b1;
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : smp
    task automatic t_regs();
        wb(0, `ADR_CTRL, 0);
        check(q, 32'h0);
        wb(0, `ADR_LOW, 0);
        check(q, 32'hF423F);
        wb(1, 4'hC, 32'hFF);
        wb(0, 4'hC, 0);
        check(q, 32'h0);
        wb(1, `ADR_CTRL, 32'h7);
        wb(0, `ADR_CTRL, 0);
        check(q, 32'h7);
        wb(1, `ADR_CTRL, 32'h0);
        $display("registers done");
    endtask : t_regs
    task automatic t_peak();
        smp(24'h64);
        smp(24'h1F4);
        smp(24'hC8);
        wb(0, `ADR_HIGH, 0);
        check(q, 32'h1F4);
        wb(0, `ADR_LOW, 0);
        check(q, 32'h64);
        pin(0, 1);
        check(disp_value_o, 24'h1F4);
        pin(0, 0);
        pin(1, 1);
        check(disp_value_o, 24'h64);
        pin(1, 0);
        check(disp_value_o, 24'hC8);
        $display("peak valley done");
    endtask : t_peak
    task automatic t_hold();
        smp(24'h12C);
        pin(3, 1);
        smp(24'h190);
        check(disp_value_o, 24'h12C);
        wb(0, `ADR_LIVE, 0);
        check(q, 32'h190);
        pin(3, 0);
        smp(24'hC8);
        check(disp_value_o, 24'hC8);
        $display("hold done");
    endtask : t_hold
    task automatic t_lock();
        pin(4, 1);
        wb(1, `ADR_ACTION, 32'h3);
        check(cnt[1] + cnt[2], 0);
        pin(4, 0);
        wb(1, `ADR_ACTION, 32'h3);
        check(cnt[1] + cnt[2], 2);
        serial_busy_i <= 1'b1;
        wb(1, `ADR_ACTION, 32'h1);
        check(cnt[2], 1);
        check(disp_msg_o, MSG_SERIAL);
        serial_busy_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        $display("lockout done");
    endtask : t_lock
    task automatic t_menu();
        in_setup_i     <= 1'b1;
        in_submenu_i   <= 1'b1;
        store_ok_i     <= 1'b1;
        menu_advance_i <= 1'b1;
        @(posedge clk_i);
        menu_advance_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check(disp_msg_o, MSG_NONE);
        menu_advance_i <= 1'b1;
        wb(1, `ADR_ACTION, 32'h4);
        check(disp_msg_o, MSG_STORED);
        store_ok_i <= 1'b0;
        wb(1, `ADR_ACTION, 32'h4);
        check(disp_msg_o, MSG_NOSTOR);
        menu_advance_i <= 1'b0;
        in_setup_i     <= 1'b0;
        repeat (20) @(posedge clk_i);
        $display("menu done");
    endtask : t_menu
    task automatic t_faults();
        msg_t m [9] = '{MSG_UOMOVF, MSG_CBOVF, MSG_SP_OVF, MSG_ROVSC, MSG_IOVSC, MSG_NOPEN, MSG_POPEN, MSG_OVLD,
                        MSG_OFS_OVF};
        int   k;
        for (int i = 0; i < 9; i++) begin
            wb(1, `ADR_FAULTS, 32'h1 << i);
            @(posedge clk_i);
            check(disp_msg_o, m[i]);
            k = 0;
            repeat (16) begin
                @(posedge clk_i);
                k += disp_blank_o;
            end
            check(k, 8);
            repeat (4) @(posedge clk_i);
        end
        wb(1, `ADR_FAULTS, 32'h18);
        check(disp_msg_o, MSG_IOVSC);
        wb(1, `ADR_FAULTS, 32'h4);
        repeat (20) @(posedge clk_i);
        check(disp_msg_o, MSG_NONE);
        smp(24'hF4240);
        check(disp_value_o, 24'hF423F);
        check(disp_msg_o, MSG_NINES);
        smp(24'hC8);
        $display("messages done");
    endtask : t_faults
    task automatic t_print();
        wb(1, `ADR_CTRL, 32'h6);
        alarm_latching_i <= 4'hF;
        sp_trip_i        <= 4'h4;
        @(posedge clk_i);
        sp_trip_i <= 4'h0;
        repeat (3) @(posedge clk_i);
        check(oe, 4'h4);
        cnt[4] = 0;
        pin(5, 1);
        check(cnt[3], 1);
        check(oe, 4'h0);
        repeat (40) @(posedge clk_i);
        check(cnt[4], 24);
        pin(5, 0);
        $display("print done");
    endtask : t_print
    task automatic t_reset_pin();
        wb(1, `ADR_CTRL, 32'h1);
        pin(2, 1);
        pin(2, 0);
        wb(0, `ADR_HIGH, 0);
        check(q, 32'h0);
        wb(0, `ADR_LOW, 0);
        check(q, 32'hF423F);
        wb(1, `ADR_CTRL, 32'h0);
        pin(2, 1);
        check(cnt[0], 1);
        check(disp_msg_o, MSG_HRESET);
        wb(0, `ADR_STATUS, 0);
        check(q, 32'h8004);
        pin(2, 0);
        $display("reset pin done");
    endtask : t_reset_pin
    task automatic close_out();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_peak();
        t_hold();
        t_lock();
        t_menu();
        t_faults();
        t_print();
        t_reset_pin();
        close_out();
    end
endmodule : testbench
